/* hdl/pspg_defines.vh */
// constants for the pattern sync pulse generator
// assumes a 32-bit classic wishbone slave port, byte addressed
`ifndef PSPG_DEFINES_VH
`define PSPG_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define PSPG_ADR_CTRL      8'h00
`define PSPG_ADR_PATLEN    8'h04
`define PSPG_ADR_ROWLEN    8'h08
`define PSPG_ADR_ROWS      8'h0C
`define PSPG_ADR_BLOCKS    8'h10
`define PSPG_ADR_DELAY     8'h14
`define PSPG_ADR_WIDTH     8'h18
`define PSPG_ADR_STATUS    8'h1C
`define PSPG_ADR_PER_LO    8'h20
`define PSPG_ADR_PER_HI    8'h24

// ****************************************
// control fields
// ****************************************
`define PSPG_CTRL_EN       0
`define PSPG_CTRL_BURST    1
`define PSPG_CTRL_TYPE_LO  2
`define PSPG_CTRL_TYPE_HI  3
`define PSPG_CTRL_CH_LO    4
`define PSPG_CTRL_CH_HI    5
`define PSPG_CTRL_RST      32'h0000_0000
`define PSPG_TYPE_MIXED    2'h3

// ****************************************
// status fields
// ****************************************
`define PSPG_ST_VALID      0
`define PSPG_ST_BUSY       1
`define PSPG_ST_ERROR      2
`define PSPG_ST_RUN        3
`define PSPG_ST_BURST      4
`define PSPG_ST_DCLAMP     5
`define PSPG_ST_WCLAMP     6

// ****************************************
// datapath granularity and minimum length in bits per channel, plus step shift and guard in steps
// ****************************************
`define PSPG_GRAN_BITS     128
`define PSPG_MIN_EXT_BITS  512
`define PSPG_STEP_SHIFT    3
`define PSPG_GUARD_STEPS   8'h10

`endif

/* hdl/pspg_period_calc.v */
// period calculator: sync period in steps of 8*N bits
// assumes start_i is a one-cycle pulse on the same clock
module pspg_period_calc #(
    parameter PW = 44,
    parameter LW = 32,
    parameter MW = 16
) (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          start_i,
    input  wire          mixed_i,
    input  wire [1:0]    nshift_i,
    input  wire [LW-1:0] len_i,
    input  wire [MW-1:0] row_len_i,
    input  wire [MW-1:0] rows_i,
    input  wire [MW-1:0] blocks_i,
    output reg           busy_o,
    output reg           valid_o,
    output reg           error_o,
    output reg  [PW-1:0] period_o
);
`include "pspg_defines.vh"

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_EXT  = 3'b010;
    localparam [2:0] S_LCM  = 3'b100;

    reg  [2:0]      state_q;
    reg  [PW-1:0]   acc_q;
    wire [PW-1:0]   len_w   = {{(PW-LW){1'b0}}, len_i};
    wire [PW-1:0]   gran_w  = {{(PW-8){1'b0}}, 8'h80} << nshift_i;
    wire [PW-1:0]   minl_w  = {{(PW-10){1'b0}}, 10'h200} << nshift_i;
    wire [3*MW-1:0] prod_w  = row_len_i * rows_i * blocks_i;

    // ****************************************
    // sequential extend then lcm by doubling
    // ****************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= S_IDLE;
            acc_q    <= {PW{1'b0}};
            busy_o   <= 1'b0;
            valid_o  <= 1'b0;
            error_o  <= 1'b0;
            period_o <= {PW{1'b0}};
        end else if (start_i) begin
            valid_o <= 1'b0;
            error_o <= 1'b0;
            if (mixed_i) begin
                // abandon any walk still running, or it would overwrite this period
                busy_o  <= 1'b0;
                state_q <= S_IDLE;
                if (prod_w == {(3*MW){1'b0}}) begin
                    error_o <= 1'b1;
                end else begin
                    period_o <= prod_w[PW-1:0] >> (`PSPG_STEP_SHIFT + nshift_i);
                    valid_o  <= 1'b1;
                end
            end else if (len_i == {LW{1'b0}}) begin
                busy_o  <= 1'b0;
                error_o <= 1'b1;
                state_q <= S_IDLE;
            end else begin
                busy_o  <= 1'b1;
                acc_q   <= len_w;
                // short patterns are repeated, longer ones are not
                state_q <= (len_w <= gran_w) ? S_EXT : S_LCM;
            end
        end else begin
            case (state_q)
                S_IDLE: begin
                    busy_o <= 1'b0;
                end
                S_EXT: begin
                    if (acc_q >= minl_w) begin
                        state_q <= S_LCM;
                    end else begin
                        acc_q <= acc_q + len_w;
                    end
                end
                S_LCM: begin
                    // granularity is a power of two, so doubling reaches the lcm
                    if ((acc_q & (gran_w - 1'b1)) == {PW{1'b0}}) begin
                        period_o <= acc_q >> (`PSPG_STEP_SHIFT + nshift_i);
                        valid_o  <= 1'b1;
                        busy_o   <= 1'b0;
                        state_q  <= S_IDLE;
                    end else begin
                        acc_q <= acc_q << 1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    busy_o  <= 1'b0;
                end
            endcase
        end
    end

endmodule // pspg_period_calc

/* hdl/pspg_top.v */
// pattern sync pulse generator with classic wishbone register port
// assumes one 40 MHz clock; each clock cycle carries one step of 8*N bits
//
// How it works
// - continuous and burst sequence modes selectable
// - continuous mode drives sync gate output
// - single channel period: lcm with 128
// - two/four channels: lcm with 256/512
// - mixed period is row*rows*blocks
// - patterns up to 128*N bits extended to 512*N or more
// - width in 8-bit steps, at most period-128
// - combined channels: 16/32-bit steps, minus 256/512
// - mixed width/delay limited to period minus guard
// - pulse placed delay steps after pattern start
// - large limits reachable with wide counters
module pspg_top #(
    parameter PW = 44,
    parameter MW = 16
) (
    input  wire        CLOCK_I,
    input  wire        NRST_I,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    output reg         GATE_O,
    output reg         PAT_START_O,
    output reg         BURST_SEL_O
);
`include "pspg_defines.vh"

    // ****************************************
    // reset release
    // ****************************************
    reg rst_s1_q;
    reg rst_n_q;

    always @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    reg  [31:0]   ctrl_q;
    reg  [31:0]   patlen_q;
    reg  [MW-1:0] rowlen_q;
    reg  [MW-1:0] rows_q;
    reg  [MW-1:0] blocks_q;
    reg  [31:0]   delay_q;
    reg  [31:0]   width_q;
    reg           recalc_q;

    wire          calc_busy;
    wire          calc_valid;
    wire          calc_error;
    wire [PW-1:0] period;

    wire          bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire          bus_wr   = bus_req & WB_WE_I;
    wire          en       = ctrl_q[`PSPG_CTRL_EN];
    wire          burst    = ctrl_q[`PSPG_CTRL_BURST];
    wire          mixed    = (ctrl_q[`PSPG_CTRL_TYPE_HI:`PSPG_CTRL_TYPE_LO] == `PSPG_TYPE_MIXED);
    wire [1:0]    ch_field = ctrl_q[`PSPG_CTRL_CH_HI:`PSPG_CTRL_CH_LO];
    // codes 0,1,2 select 1,2,4 channels; code 3 falls back to four
    wire [1:0]    nshift   = (ch_field == 2'h3) ? 2'h2 : ch_field;

    function [31:0] wmerge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel_v;
        integer      k;
        begin
            wmerge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel_v[k]) begin
                    wmerge[8*k +: 8] = new_v[8*k +: 8];
                end
            end
        end
    endfunction

    wire [31:0] row_pad  = {{(32-MW){1'b0}}, rowlen_q};
    wire [31:0] rows_pad = {{(32-MW){1'b0}}, rows_q};
    wire [31:0] blk_pad  = {{(32-MW){1'b0}}, blocks_q};
    wire [31:0] row_new  = wmerge(row_pad, WB_DAT_I, WB_SEL_I);
    wire [31:0] rows_new = wmerge(rows_pad, WB_DAT_I, WB_SEL_I);
    wire [31:0] blk_new  = wmerge(blk_pad, WB_DAT_I, WB_SEL_I);

    // any write that changes the period shape forces a new period
    wire shape_wr = bus_wr & ((WB_ADR_I == `PSPG_ADR_CTRL) | (WB_ADR_I == `PSPG_ADR_PATLEN) |
                              (WB_ADR_I == `PSPG_ADR_ROWLEN) | (WB_ADR_I == `PSPG_ADR_ROWS) |
                              (WB_ADR_I == `PSPG_ADR_BLOCKS));

    always @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q   <= `PSPG_CTRL_RST;
            patlen_q <= 32'h0000_0000;
            rowlen_q <= {MW{1'b0}};
            rows_q   <= {MW{1'b0}};
            blocks_q <= {MW{1'b0}};
            delay_q  <= 32'h0000_0000;
            width_q  <= 32'h0000_0000;
            recalc_q <= 1'b0;
        end else begin
            recalc_q <= shape_wr;
            if (bus_wr) begin
                case (WB_ADR_I)
                    `PSPG_ADR_CTRL:   ctrl_q   <= wmerge(ctrl_q, WB_DAT_I, WB_SEL_I) & 32'h0000_003F;
                    `PSPG_ADR_PATLEN: patlen_q <= wmerge(patlen_q, WB_DAT_I, WB_SEL_I);
                    `PSPG_ADR_ROWLEN: rowlen_q <= row_new[MW-1:0];
                    `PSPG_ADR_ROWS:   rows_q   <= rows_new[MW-1:0];
                    `PSPG_ADR_BLOCKS: blocks_q <= blk_new[MW-1:0];
                    `PSPG_ADR_DELAY:  delay_q  <= wmerge(delay_q, WB_DAT_I, WB_SEL_I);
                    `PSPG_ADR_WIDTH:  width_q  <= wmerge(width_q, WB_DAT_I, WB_SEL_I);
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // period calculation
    // ****************************************
    // patterns under 512*N bits are expected already replicated by software,
    // but the calculator extends those of 128*N bits or less anyway so a slip still yields a valid period
    pspg_period_calc #(
        .PW (PW),
        .LW (32),
        .MW (MW)
    ) u_calc (
        .clk_i     (CLOCK_I),
        .rst_n_i   (rst_n_q),
        .start_i   (recalc_q),
        .mixed_i   (mixed),
        .nshift_i  (nshift),
        .len_i     (patlen_q),
        .row_len_i (rowlen_q),
        .rows_i    (rows_q),
        .blocks_i  (blocks_q),
        .busy_o    (calc_busy),
        .valid_o   (calc_valid),
        .error_o   (calc_error),
        .period_o  (period)
    );

    // ****************************************
    // delay and width limits
    // ****************************************
    // one step is 8, 16 or 32 bits, so the guard of 128*N bits is always 16 steps
    wire [PW-1:0] guard    = {{(PW-8){1'b0}}, `PSPG_GUARD_STEPS};
    wire [PW-1:0] limit    = (period > guard) ? (period - guard) : {PW{1'b0}};
    wire [PW-1:0] dly_req  = {{(PW-32){1'b0}}, delay_q};
    wire [PW-1:0] wid_req  = {{(PW-32){1'b0}}, width_q};
    wire          dly_clip = (dly_req > limit);
    wire          wid_clip = (wid_req > limit);
    // out-of-range settings saturate instead of producing a broken pulse
    wire [PW-1:0] dly_eff  = dly_clip ? limit : dly_req;
    wire [PW-1:0] wid_eff  = wid_clip ? limit : wid_req;

    // ****************************************
    // step counter and gate
    // ****************************************
    reg  [PW-1:0] cnt_q;
    wire          run     = en & ~burst & calc_valid & ~calc_busy;
    wire [PW-1:0] cnt_end = period - 1'b1;
    // position relative to the pulse start, wrapped into the period
    wire [PW-1:0] offset  = (cnt_q >= dly_eff) ? (cnt_q - dly_eff) : (cnt_q + period - dly_eff);
    wire          gate_d  = run & (offset < wid_eff);

    always @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q       <= {PW{1'b0}};
            GATE_O      <= 1'b0;
            PAT_START_O <= 1'b0;
            BURST_SEL_O <= 1'b0;
        end else begin
            BURST_SEL_O <= en & burst;
            if (!run) begin
                cnt_q       <= {PW{1'b0}};
                GATE_O      <= 1'b0;
                PAT_START_O <= 1'b0;
            end else begin
                // back to back periods, no idle step between them
                cnt_q       <= (cnt_q >= cnt_end) ? {PW{1'b0}} : (cnt_q + 1'b1);
                GATE_O      <= gate_d;
                PAT_START_O <= (cnt_q == {PW{1'b0}});
            end
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    wire [31:0] status = {25'h0000000, wid_clip, dly_clip, burst, run, calc_error, calc_busy, calc_valid};
    // wide period words let the full 17.6e12-step range be read back
    wire [63:0] per_wide = {{(64-PW){1'b0}}, period};
    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (WB_ADR_I)
            `PSPG_ADR_CTRL:   rd_mux = ctrl_q;
            `PSPG_ADR_PATLEN: rd_mux = patlen_q;
            `PSPG_ADR_ROWLEN: rd_mux = row_pad;
            `PSPG_ADR_ROWS:   rd_mux = rows_pad;
            `PSPG_ADR_BLOCKS: rd_mux = blk_pad;
            `PSPG_ADR_DELAY:  rd_mux = delay_q;
            `PSPG_ADR_WIDTH:  rd_mux = width_q;
            `PSPG_ADR_STATUS: rd_mux = status;
            `PSPG_ADR_PER_LO: rd_mux = per_wide[31:0];
            `PSPG_ADR_PER_HI: rd_mux = per_wide[63:32];
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req & ~WB_WE_I) begin
                WB_DAT_O <= rd_mux;
            end
        end
    end

endmodule // pspg_top

/* sim/pspg_chk.sv */
// port checker for the pattern sync pulse generator
// assumes binding to pspg_top; one clock, async active-low reset
`include "pspg_defines.vh"
module pspg_chk (
    input wire logic        CLOCK_I,
    input wire logic        NRST_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        GATE_O,
    input wire logic        PAT_START_O,
    input wire logic        BURST_SEL_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_q;
    logic bexp_q;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    // ****************************************
    // control write tracker
    // ****************************************
    always @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wr_q   <= 1'b0;
            bexp_q <= 1'b0;
        end else begin
            wr_q <= WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == `PSPG_ADR_CTRL && WB_SEL_I[0];
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == `PSPG_ADR_CTRL && WB_SEL_I[0])
                bexp_q <= WB_DAT_I[0] && WB_DAT_I[1];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
    read_hold_a: assert property (!WB_ACK_O |-> $stable(WB_DAT_O)) else $error("read data moved without ack");
    start_cont_a: assert property (PAT_START_O |-> !BURST_SEL_O) else $error("start pulse in burst");
    burst_quiet_a: assert property (BURST_SEL_O && $past(BURST_SEL_O) && $past(BURST_SEL_O, 2) |-> !GATE_O)
        else $error("gate active in burst");
    burst_sel_a: assert property (wr_q |-> ##[0:1] BURST_SEL_O == bexp_q)
        else $error("burst select wrong");
    burst_cause_a: assert property (!$stable(BURST_SEL_O) |-> wr_q || $past(wr_q))
        else $error("burst select moved alone");
endmodule // pspg_chk

/* sim/pspg_partner.sv */
// model of the test equipment triggered by the sync gate
// assumes gate and start pulse are registered on clk_i
module pspg_partner (
    input  wire logic clk_i,
    input  wire logic gate_i,
    input  wire logic start_i,
    output int        per_o,
    output int        wid_o,
    output int        dly_o,
    output int        starts_o,
    output int        high_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int   s = 0;
    int   h = 0;
    logic g_q = 1'b0;
    initial {per_o, wid_o, dly_o, starts_o, high_o} = '0;
    // ****************************************
    // period, width and offset measurement
    // ****************************************
    always @(posedge clk_i) begin
        g_q <= gate_i;
        if (start_i === 1'b1) begin
            per_o    <= s;
            s        <= 1;
            starts_o <= starts_o + 1;
        end else begin
            s <= s + 1;
        end
        if (gate_i === 1'b1) begin
            h      <= h + 1;
            high_o <= high_o + 1;
            // offset counts from the last start, zero if both coincide
            if (g_q !== 1'b1) dly_o <= (start_i === 1'b1) ? 0 : s;
        end else if (h != 0) begin
            wid_o <= h;
            h     <= 0;
        end
    end
endmodule // pspg_partner

/* sim/pspg_top_bench.sv */
// testbench for the pattern sync pulse generator
// assumes the checker and equipment model are compiled first
`include "pspg_defines.vh"
module pspg_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    wire  [31:0] dat_r;
    wire         ack, gate, pstart, bsel;
    int          num_errors, n_checks, per_m, wid_m, dly_m, starts, hi_cyc;
    pspg_top dut (.CLOCK_I(clk), .NRST_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .GATE_O(gate),
        .PAT_START_O(pstart), .BURST_SEL_O(bsel));
    pspg_partner eq (.clk_i(clk), .gate_i(gate), .start_i(pstart), .per_o(per_m), .wid_o(wid_m),
        .dly_o(dly_m), .starts_o(starts), .high_o(hi_cyc));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task test_done;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, d};
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
        if (i == 20) begin
            num_errors++;
            test_done;
        end
        q = dat_r;
        {cyc, stb} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task wait_starts(input int n);
        int i, b;
        b = starts;
        for (i = 0; i < 20000 && starts < b + n; i++) @(posedge clk);
        if (i == 20000) begin
            num_errors++;
            test_done;
        end
    endtask
    // program shape, restart, then compare period, width and offset
    task run(input logic [31:0] ctl, len, row, rows, blk, d, w, per);
        logic [31:0] q;
        int i;
        wr(`PSPG_ADR_PATLEN, len);
        wr(`PSPG_ADR_ROWLEN, row);
        wr(`PSPG_ADR_ROWS, rows);
        wr(`PSPG_ADR_BLOCKS, blk);
        wr(`PSPG_ADR_DELAY, d);
        wr(`PSPG_ADR_WIDTH, w);
        wr(`PSPG_ADR_CTRL, ctl);
        q = '0;
        for (i = 0; i < 2000 && q[1:0] !== 2'b01; i++) wb(1'b0, `PSPG_ADR_STATUS, '0, q);
        wb(1'b0, `PSPG_ADR_PER_LO, '0, q);
        chk(q, per);
        wait_starts(3);
        chk(per_m, per);
        chk(wid_m, w);
        chk(dly_m, d);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        logic [31:0] q;
        wb(1'b0, `PSPG_ADR_CTRL, '0, q);
        chk(q, `PSPG_CTRL_RST);
        wb(1'b0, 8'h28, '0, q);
        chk(q, 32'h0);
        wr(`PSPG_ADR_DELAY, 32'h0000_0123);
        wb(1'b0, `PSPG_ADR_DELAY, '0, q);
        chk(q, 32'h0000_0123);
        $display("test regs done");
    endtask
    task t_single;
        run(32'h01, 1000, 0, 0, 0, 10, 5, 2000);
        run(32'h05, 100, 0, 0, 0, 4, 6, 1200);
        run(32'h05, 600, 0, 0, 0, 4, 6, 1200);
        $display("test single channel done");
    endtask
    task t_comb;
        run(32'h19, 1000, 0, 0, 0, 7, 3, 2000);
        run(32'h21, 1000, 0, 0, 0, 2, 9, 2000);
        run(32'h31, 1000, 0, 0, 0, 5, 4, 2000);
        $display("test combined channels done");
    endtask
    task t_mixed;
        logic [31:0] q;
        int h;
        run(32'h0D, 1000, 64, 4, 2, 3, 7, 64);
        wr(`PSPG_ADR_DELAY, 100);
        wb(1'b0, `PSPG_ADR_STATUS, '0, q);
        chk(q[`PSPG_ST_DCLAMP], 1'b1);
        wr(`PSPG_ADR_WIDTH, 0);
        wait_starts(1);
        h = hi_cyc;
        wait_starts(3);
        chk(hi_cyc - h, 0);
        $display("test mixed done");
    endtask
    task t_burst;
        logic [31:0] q;
        int b, h;
        wr(`PSPG_ADR_WIDTH, 5);
        wr(`PSPG_ADR_CTRL, 32'h03);
        wb(1'b0, `PSPG_ADR_STATUS, '0, q);
        chk(q[`PSPG_ST_BURST], 1'b1);
        chk(bsel, 1'b1);
        b = starts;
        h = hi_cyc;
        repeat (200) @(posedge clk);
        chk(starts - b, 0);
        chk(hi_cyc - h, 0);
        $display("test burst done");
    endtask
    initial begin
        {rst_n, cyc, stb, we, adr, dat_w} = '0;
        sel = 4'hF;
        num_errors = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs;
        t_single;
        t_comb;
        t_mixed;
        t_burst;
        test_done;
    end
endmodule // pspg_top_bench
bind pspg_top pspg_chk chk_i (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .GATE_O(GATE_O), .PAT_START_O(PAT_START_O), .BURST_SEL_O(BURST_SEL_O));
